/* File: rtl/hbpm_ctrl.sv */
// Half-bridge PWM, mode and reset control with register port
// What this block does
// - Power-on reset clears configuration, outputs off
// - Power-stage supply dropout keeps stored registers
// - Enable high gives normal, configurable mode
// - Enable low: outputs off, registers reset
// - Undriven enable reads low, hence sleep
// - Logic undervoltage clears logic, outputs off
// - Reset report flag reads zero after reset
// - With no channel, activation bits hold switches statically on
// - Bridge picks one of three channels, 8-bit duty
// - Codes 01/10/11 give 80/100/200 Hz, fast 2 kHz
// - Rate code 00 stops the channel unless its fast bit is set
// - Selecting a running rate starts the period
// - Duty and rate changes apply glitch-free
// - Freewheel drives complementary switch in off phase
// - Freewheel needs on-times above both dead times
// - Stopped channel with freewheel: activated switch off, complementary on
// - No channel, no activation: both switches off
// - Fault condition pulls fault pin low
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/1ns
`include "hbpm_params.svh"

module hbpm_ctrl import hbpm_pkg::*; #(
	parameter int NB       = 12,
	parameter int NCH      = 3,
	parameter int PRE_W    = 13,
	parameter int DEAD_W   = 4,
	parameter int STEP_C1  = `HBPM_STEP_CYC(`HBPM_RATE1_HZ),
	parameter int STEP_C2  = `HBPM_STEP_CYC(`HBPM_RATE2_HZ),
	parameter int STEP_C3  = `HBPM_STEP_CYC(`HBPM_RATE3_HZ),
	parameter int STEP_2K  = `HBPM_STEP_CYC(`HBPM_FAST_HZ),
	parameter int DEAD_CYC = `HBPM_DEAD_CYC
) (
	// Clock and reset
	input  wire logic          MCLK_I,
	input  wire logic          RESETN_I,
	// Device pins
	input  wire logic          EN_I,
	input  wire logic          VS_OK_I,
	input  wire logic          FAULT_I,
	output logic               FAULT_INDICATOR_PIN_N_O,
	// Register port
	input  wire logic [7:0]    ADDR_I,
	input  wire logic [31:0]   WDATA_I,
	input  wire logic          WR_I,
	input  wire logic          RD_I,
	output logic      [31:0]   RDATA_O,
	// Switch drives
	output logic      [NB-1:0] HS_O,
	output logic      [NB-1:0] LS_O
);

	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	if (NB < 1 || NB > 16 || NCH != 3)
		$error("hbpm_ctrl: bridge or channel count out of range");
	if (STEP_C1 < 1 || STEP_C1 >= 2**PRE_W || STEP_2K < 1)
		$error("hbpm_ctrl: step length does not fit prescaler");
	if (DEAD_CYC < 1 || DEAD_CYC >= 2**DEAD_W)
		$error("hbpm_ctrl: dead time does not fit counter");

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic                            en_m;
		logic                            en_s;
		logic                            vs_m;
		logic                            vs_s;
		logic                            flt_m;
		logic                            flt_s;
		hbpm_mode_t                      mode;
		logic                            flag;
		logic                            fault_n;
		logic [31:0]                     rdata;
		logic [2*NB-1:0]                 act;
		logic [NB-1:0][1:0]              chan_sel;
		logic [NB-1:0]                   freewheel;
		logic [NCH-1:0][`HBPM_DUTY_W-1:0] duty;
		logic [NCH-1:0][1:0]             rate;
		logic [NCH-1:0]                  fast;
		logic [NCH-1:0][`HBPM_DUTY_W-1:0] duty_a;
		logic [NCH-1:0][2:0]             rate_a;
		logic [NCH-1:0][PRE_W-1:0]       pre;
		logic [NCH-1:0][`HBPM_DUTY_W-1:0] step;
		logic [NB-1:0]                   hs;
		logic [NB-1:0]                   ls;
		logic [NB-1:0][DEAD_W-1:0]       dead;
	} hbpm_state_t;

	hbpm_state_t    s;
	hbpm_state_t    next_s;
	logic [NCH-1:0] run;
	logic [NCH-1:0] pwm_on;
	logic [NCH-1:0] fw_ok;
	logic [NCH-1:0] wrap;
	logic           normal;

	// Step length in clock cycles for an active rate selection
	function automatic logic [PRE_W-1:0] step_len(input logic [2:0] r);
		logic [PRE_W-1:0] l;
		l = PRE_W'(STEP_C1);
		if (r[2])
			l = PRE_W'(STEP_2K);
		else if (r[1:0] == `HBPM_RATE_C2)
			l = PRE_W'(STEP_C2);
		else if (r[1:0] == `HBPM_RATE_C3)
			l = PRE_W'(STEP_C3);
		return l;
	endfunction

	// Both switch on-times must exceed the two dead times together
	function automatic logic freewheel_ok(input logic [7:0] d, input logic [PRE_W-1:0] l);
		int on_t;
		int off_t;
		on_t  = int'(d) * int'(l);
		off_t = (`HBPM_STEPS - int'(d)) * int'(l);
		return (on_t > 2 * DEAD_CYC) && (off_t > 2 * DEAD_CYC);
	endfunction

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		logic [PRE_W-1:0] len;
		logic [1:0]       ch;
		logic             pwm;
		logic             fwe;
		logic             req_h;
		logic             req_l;
		int               ci;
		len    = '0;
		ch     = 2'h0;
		pwm    = 1'b0;
		fwe    = 1'b0;
		req_h  = 1'b0;
		req_l  = 1'b0;
		ci     = 0;
		next_s = s;
		run    = '0;
		pwm_on = '0;
		fw_ok  = '0;
		wrap   = '0;

		// Pin synchronisers; enable pulled low when undriven upstream
		next_s.en_m  = EN_I;
		next_s.en_s  = s.en_m;
		next_s.vs_m  = VS_OK_I;
		next_s.vs_s  = s.vs_m;
		next_s.flt_m = FAULT_I;
		next_s.flt_s = s.flt_m;

		// Mode follows the enable pin
		next_s.mode = s.en_s ? HBPM_NORMAL : HBPM_SLEEP;
		unique case (s.mode)
			HBPM_NORMAL: normal = 1'b1;
			HBPM_SLEEP:  normal = 1'b0;
			default:     normal = 1'b0;
		endcase

		// Fault indicator, active low
		next_s.fault_n = ~s.flt_s;

		// Register writes, only in normal mode
		if (WR_I && normal) begin
			case (ADDR_I)
				`HBPM_ADR_ACT:    next_s.act = WDATA_I[2*NB-1:0];
				`HBPM_ADR_CHSEL:  next_s.chan_sel = WDATA_I[2*NB-1:0];
				`HBPM_ADR_FREEWH: next_s.freewheel = WDATA_I[NB-1:0];
				`HBPM_ADR_DUTY:   next_s.duty = WDATA_I[NCH*`HBPM_DUTY_W-1:0];
				`HBPM_ADR_RATE:   next_s.rate = WDATA_I[2*NCH-1:0];
				`HBPM_ADR_FAST:   next_s.fast = WDATA_I[NCH-1:0];
				`HBPM_ADR_STATUS: begin
					if (WDATA_I[`HBPM_ST_FLAG])
						next_s.flag = 1'b1;
				end
				default: ;
			endcase
		end

		// Register reads, data in the following cycle
		next_s.rdata = '0;
		if (RD_I) begin
			case (ADDR_I)
				`HBPM_ADR_ACT:    next_s.rdata[2*NB-1:0] = s.act;
				`HBPM_ADR_CHSEL:  next_s.rdata[2*NB-1:0] = s.chan_sel;
				`HBPM_ADR_FREEWH: next_s.rdata[NB-1:0] = s.freewheel;
				`HBPM_ADR_DUTY:   next_s.rdata[NCH*`HBPM_DUTY_W-1:0] = s.duty;
				`HBPM_ADR_RATE:   next_s.rdata[2*NCH-1:0] = s.rate;
				`HBPM_ADR_FAST:   next_s.rdata[NCH-1:0] = s.fast;
				`HBPM_ADR_STATUS: begin
					next_s.rdata[`HBPM_ST_FLAG]   = s.flag;
					next_s.rdata[`HBPM_ST_FAULT]  = s.flt_s;
					next_s.rdata[`HBPM_ST_NORMAL] = normal;
					next_s.rdata[`HBPM_ST_VSOK]   = s.vs_s;
				end
				default: ;
			endcase
		end

		// Sleep resets all register banks and the report flag
		if (!normal) begin
			next_s.act       = '0;
			next_s.chan_sel  = '0;
			next_s.freewheel = '0;
			next_s.duty      = '0;
			next_s.rate      = '0;
			next_s.fast      = '0;
			next_s.flag      = 1'b0;
		end

		// PWM channels
		for (int c = 0; c < NCH; c++) begin
			run[c]    = s.fast[c] | (s.rate[c] != `HBPM_RATE_STOP);
			len       = step_len(s.rate_a[c]);
			pwm_on[c] = s.step[c] < s.duty_a[c];
			fw_ok[c]  = freewheel_ok(s.duty_a[c], len);
			wrap[c]   = run[c] && (s.pre[c] == len - PRE_W'(1)) && (s.step[c] == 8'hff);
			if (!run[c]) begin
				// Stopped: counters parked; settings follow the values being
				// written, so the first period already runs at the new rate
				next_s.pre[c]    = '0;
				next_s.step[c]   = '0;
				next_s.duty_a[c] = next_s.duty[c];
				next_s.rate_a[c] = {next_s.fast[c], next_s.rate[c]};
			end else if (s.pre[c] == len - PRE_W'(1)) begin
				next_s.pre[c]  = '0;
				next_s.step[c] = s.step[c] + 8'h01;
				if (s.step[c] == 8'hff) begin
					// New settings only at period boundary
					next_s.duty_a[c] = s.duty[c];
					next_s.rate_a[c] = {s.fast[c], s.rate[c]};
				end
			end else begin
				next_s.pre[c] = s.pre[c] + PRE_W'(1);
			end
		end

		// Half-bridge drive requests and dead time
		for (int b = 0; b < NB; b++) begin
			ch    = s.chan_sel[b];
			req_h = 1'b0;
			req_l = 1'b0;
			if (ch == 2'h0) begin
				req_h = s.act[b];
				req_l = s.act[NB+b];
			end else begin
				ci  = int'(ch) - 1;
				pwm = run[ci] & pwm_on[ci];
				fwe = s.freewheel[b] & (~run[ci] | fw_ok[ci]);
				if (s.act[b]) begin
					req_h = pwm;
					req_l = fwe & ~pwm;
				end else if (s.act[NB+b]) begin
					req_l = pwm;
					req_h = fwe & ~pwm;
				end
			end
			// Never both switches of one bridge
			if (req_h && req_l) begin
				req_h = 1'b0;
				req_l = 1'b0;
			end
			// Outputs off in sleep or supply dropout; registers kept in dropout
			if (!normal || !s.vs_s) begin
				req_h = 1'b0;
				req_l = 1'b0;
			end
			if (s.dead[b] != '0)
				next_s.dead[b] = s.dead[b] - DEAD_W'(1);
			if ({req_h, req_l} != {s.hs[b], s.ls[b]}) begin
				if (s.hs[b] || s.ls[b]) begin
					// Turn off first, then wait out the dead time
					next_s.hs[b]   = 1'b0;
					next_s.ls[b]   = 1'b0;
					next_s.dead[b] = DEAD_W'(DEAD_CYC);
				end else if (s.dead[b] == '0) begin
					next_s.hs[b] = req_h;
					next_s.ls[b] = req_l;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// State register, reset clears all but mode (to sleep) and fault pin (high)
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK_I) begin
		if (!RESETN_I) begin
			s         <= '0;
			s.mode    <= HBPM_SLEEP;
			s.fault_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from flip-flops
	assign HS_O                    = s.hs;
	assign LS_O                    = s.ls;
	assign RDATA_O                 = s.rdata;
	assign FAULT_INDICATOR_PIN_N_O = s.fault_n;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!RESETN_I);

	// Bridge 2 carries channel 1 with freewheel, so its dead times are watched
	sequence hs2_falls;
		$fell(s.hs[2]);
	endsequence

	sequence ls2_held_off;
		!s.ls[2] [*8];
	endsequence

	sequence ls2_falls;
		$fell(s.ls[2]);
	endsequence

	sequence hs2_held_off;
		!s.hs[2] [*8];
	endsequence

	chk_sleep_outs_off: assert property (s.mode == HBPM_SLEEP |=> HS_O == '0 && LS_O == '0)
		else $error("outputs on in sleep mode");
	chk_sleep_bank_clear: assert property (s.mode == HBPM_SLEEP |=> s.act == '0 && s.duty == '0)
		else $error("register bank kept in sleep");
	chk_flag_after_wake: assert property ($rose(normal) |-> s.flag == 1'b0)
		else $error("report flag set on wake");
	chk_no_cross_drive: assert property (!(|(HS_O & LS_O)))
		else $error("both switches of a bridge on");
	chk_dead_time_gap: assert property (hs2_falls |-> ls2_held_off)
		else $error("low side on within dead time");
	chk_fault_pin_low: assert property (s.flt_s |=> !FAULT_INDICATOR_PIN_N_O)
		else $error("fault pin not low on fault");
	chk_stop_no_count: assert property (!run[0] |=> s.step[0] == '0 && s.pre[0] == '0)
		else $error("stopped channel still counting");
	chk_period_start: assert property ($rose(run[0]) |-> s.step[0] == '0 ##1 s.pre[0] == 1)
		else $error("period not started on rate select");
	chk_duty_glitchless: assert property ($changed(s.duty_a[0]) |-> $past(wrap[0] || !run[0]))
		else $error("duty changed inside a period");
	chk_vs_keeps_regs: assert property (!s.vs_s && !$past(WR_I) && normal && $past(normal)
		|-> s.act == $past(s.act))
		else $error("registers lost during supply dropout");
	chk_stop_freewheel: assert property (normal && s.vs_s && s.chan_sel[2] == 2'h1 && !run[0]
		&& s.freewheel[2] && s.act[2] && !s.act[NB+2] [*3] |-> ##[1:20] (LS_O[2] && !HS_O[2]))
		else $error("stopped freewheel did not enable low side");
	chk_static_on: assert property (normal && s.vs_s && s.chan_sel[0] == 2'h0 && s.act[0]
		&& !s.act[NB] [*3] |-> ##[1:20] HS_O[0])
		else $error("activated switch not held on");

	// Dead time back to high side, pins, mode, read port and freewheel off phase
	chk_dead_time_back: assert property (ls2_falls |-> hs2_held_off)
		else $error("high side on within dead time");
	chk_fault_pin_high: assert property (!s.flt_s |=> FAULT_INDICATOR_PIN_N_O)
		else $error("fault pin low without fault");
	chk_en_low_sleeps: assert property (!s.en_s |=> s.mode == HBPM_SLEEP)
		else $error("low enable did not give sleep");
	chk_en_high_normal: assert property (s.en_s |=> s.mode == HBPM_NORMAL)
		else $error("high enable did not give normal mode");
	chk_read_one_cycle: assert property (!$past(RD_I) |-> RDATA_O == '0)
		else $error("read data outside its cycle");
	chk_fw_off_phase: assert property (s.chan_sel[2] == 2'h1 && s.act[2]
		&& !pwm_on[0] |=> !HS_O[2])
		else $error("high side on in off phase");

endmodule

/* File: rtl/hbpm_params.svh */
// Constants of the half-bridge PWM and mode control block
`ifndef HBPM_PARAMS_SVH
`define HBPM_PARAMS_SVH

// ----------------------------------------------------------------
// Clock and time base
// ----------------------------------------------------------------
`define HBPM_CLK_MHZ      125
`define HBPM_CLK_HZ       (`HBPM_CLK_MHZ * 1000000)
`define HBPM_STEPS        256
`define HBPM_DUTY_W       8
`define HBPM_RATE1_HZ     80
`define HBPM_RATE2_HZ     100
`define HBPM_RATE3_HZ     200
`define HBPM_FAST_HZ      2000
`define HBPM_STEP_CYC(f)  (`HBPM_CLK_HZ / ((f) * `HBPM_STEPS))
`define HBPM_DEAD_NS      64
`define HBPM_DEAD_CYC     ((`HBPM_DEAD_NS * `HBPM_CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define HBPM_ADR_ACT      8'h00
`define HBPM_ADR_CHSEL    8'h04
`define HBPM_ADR_FREEWH   8'h08
`define HBPM_ADR_DUTY     8'h0c
`define HBPM_ADR_RATE     8'h10
`define HBPM_ADR_FAST     8'h14
`define HBPM_ADR_STATUS   8'h18

// ----------------------------------------------------------------
// Status register bits and codes
// ----------------------------------------------------------------
`define HBPM_ST_FLAG      0
`define HBPM_ST_FAULT     1
`define HBPM_ST_NORMAL    2
`define HBPM_ST_VSOK      3
`define HBPM_RATE_STOP    2'h0
`define HBPM_RATE_C1      2'h1
`define HBPM_RATE_C2      2'h2
`define HBPM_RATE_C3      2'h3

`endif

/* File: rtl/hbpm_pkg.sv */
// Types of the half-bridge PWM and mode control block
package hbpm_pkg;
	typedef enum logic [1:0] {
		HBPM_SLEEP  = 2'b01,
		HBPM_NORMAL = 2'b10
	} hbpm_mode_t;
endpackage

/* File: bench/hbpm_host.sv */
// Host side model of the enable pin with its pull-down
`timescale 1ns/1ns

module hbpm_host (
	// Host controls
	input  wire logic en_drive_i,
	input  wire logic en_oe_i,
	// Device pin
	output logic      en_o
);
	// Undriven enable settles at the pull-down level
	assign en_o = en_oe_i ? en_drive_i : 1'b0;
endmodule

/* File: bench/hbpm_ctrl_test.sv */
// Self-checking testbench of the half-bridge PWM and mode control block
`timescale 1ns/1ns
`include "hbpm_params.svh"

module hbpm_ctrl_test;
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	localparam int STEPS [4] = '{4, 3, 2, 1};
	logic        clk;
	logic        rst_n;
	logic        en_drive;
	logic        en_oe;
	logic        en;
	logic        vs_ok;
	logic        fault;
	logic        fault_n;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic        wr_s;
	logic        rd_s;
	logic [31:0] rdata;
	logic [11:0] hs;
	logic [11:0] ls;
	logic [31:0] d;
	int          failures;
	int          total_checks;
	int          hi;
	int          lo;
	int          n;

	hbpm_host host (.en_drive_i(en_drive), .en_oe_i(en_oe), .en_o(en));

	hbpm_ctrl #(.STEP_C1(4), .STEP_C2(3), .STEP_C3(2), .STEP_2K(1)) DUT (
		.MCLK_I(clk), .RESETN_I(rst_n), .EN_I(en), .VS_OK_I(vs_ok), .FAULT_I(fault),
		.FAULT_INDICATOR_PIN_N_O(fault_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s),
		.RD_I(rd_s), .RDATA_O(rdata), .HS_O(hs), .LS_O(ls)
	);

	// Free-running 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task report_and_stop;
		$display("Checks %0d, failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		wr_s  <= 1'b1;
		addr  <= a;
		wdata <= v;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	task rd(input logic [7:0] a);
		@(posedge clk);
		rd_s <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 d = rdata;
	endtask

	task wait_out(input logic [11:0] eh, input logic [11:0] el);
		int k;
		k = 0;
		#1;
		while ((hs !== eh || ls !== el) && k < 60) begin
			@(posedge clk);
			#1 k++;
		end
		chk({8'h00, hs, ls}, {8'h00, eh, el}, "switch drive");
	endtask

	task hold_out(input logic [11:0] eh, input logic [11:0] el, input int c);
		int bad;
		bad = 0;
		repeat (c) begin
			@(posedge clk);
			#1 if (hs !== eh || ls !== el) bad++;
		end
		chk(32'(bad), 32'h0, "drive moved");
	endtask

	task wait_hs2(input logic v, output int k);
		k = 0;
		while (hs[2] !== v && k < 3000) begin
			@(posedge clk);
			#1 k++;
		end
		if (k == 3000) begin
			failures++;
			$display("BAD %0t pwm edge missing", $time);
			report_and_stop;
		end
	endtask

	task measure;
		wait_hs2(1'b0, n);
		wait_hs2(1'b1, n);
		wait_hs2(1'b0, hi);
		wait_hs2(1'b1, lo);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		en_drive = 1'b0;
		en_oe = 1'b0;
		vs_ok = 1'b1;
		fault = 1'b0;
		addr = 8'h00;
		wdata = 32'h0;
		wr_s = 1'b0;
		rd_s = 1'b0;
		failures = 0;
		total_checks = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		// Sleep after power-on, writes ignored
		rd(`HBPM_ADR_STATUS);
		chk(d, 32'h8, "status sleep");
		chk({8'h00, hs, ls}, 32'h0, "outputs at reset");
		wr(`HBPM_ADR_ACT, 32'h1);
		rd(`HBPM_ADR_ACT);
		chk(d, 32'h0, "write in sleep");
		// Normal mode and report flag
		@(posedge clk);
		en_oe <= 1'b1;
		en_drive <= 1'b1;
		repeat (6) @(posedge clk);
		rd(`HBPM_ADR_STATUS);
		chk(d, 32'hc, "status normal");
		wr(`HBPM_ADR_STATUS, 32'h1);
		rd(`HBPM_ADR_STATUS);
		chk(d, 32'hd, "flag set");
		rd(8'h1c);
		chk(d, 32'h0, "unmapped read");
		// Continuous drive and supply dropout
		wr(`HBPM_ADR_ACT, 32'h2001);
		wait_out(12'h001, 12'h002);
		rd(`HBPM_ADR_ACT);
		chk(d, 32'h2001, "activation readback");
		@(posedge clk);
		vs_ok <= 1'b0;
		wait_out(12'h000, 12'h000);
		@(posedge clk);
		vs_ok <= 1'b1;
		wait_out(12'h001, 12'h002);
		// Fault pin
		@(posedge clk);
		fault <= 1'b1;
		repeat (4) @(posedge clk);
		#1 chk({31'h0, fault_n}, 32'h0, "fault pin low");
		rd(`HBPM_ADR_STATUS);
		chk(d, 32'hf, "fault status");
		@(posedge clk);
		fault <= 1'b0;
		repeat (4) @(posedge clk);
		#1 chk({31'h0, fault_n}, 32'h1, "fault pin high");
		// PWM set-up in the recommended order
		wr(`HBPM_ADR_RATE, 32'h0);
		wr(`HBPM_ADR_CHSEL, 32'h10);
		wr(`HBPM_ADR_DUTY, 32'h40);
		wr(`HBPM_ADR_RATE, 32'h1);
		wr(`HBPM_ADR_ACT, 32'h2005);
		for (int i = 0; i < 4; i++) begin
			if (i < 3) begin
				wr(`HBPM_ADR_RATE, 32'(i + 1));
			end else begin
				wr(`HBPM_ADR_FAST, 32'h1);
			end
			measure;
			measure;
			chk(32'(hi + lo), 32'(256 * STEPS[i]), "pwm period");
			chk(32'(hi), 32'(64 * STEPS[i]), "pwm on time");
		end
		wr(`HBPM_ADR_DUTY, 32'h80);
		measure;
		measure;
		chk(32'(hi), 32'h80, "duty change");
		// Freewheel on the running channel, then stopped with and without it
		wr(`HBPM_ADR_FREEWH, 32'h4);
		n = 0;
		repeat (300) begin
			@(posedge clk);
			#1 if (ls[2] === 1'b1) n++;
		end
		chk(32'(n > 0 && n < 300), 32'h1, "freewheel low side");
		wr(`HBPM_ADR_FAST, 32'h0);
		wr(`HBPM_ADR_RATE, 32'h0);
		wait_out(12'h001, 12'h006);
		hold_out(12'h001, 12'h006, 300);
		wr(`HBPM_ADR_FREEWH, 32'h0);
		wait_out(12'h001, 12'h002);
		// Sleep clears outputs, configuration and report flag; released enable sleeps
		@(posedge clk);
		en_drive <= 1'b0;
		wait_out(12'h000, 12'h000);
		@(posedge clk);
		en_drive <= 1'b1;
		repeat (6) @(posedge clk);
		rd(`HBPM_ADR_ACT);
		chk(d, 32'h0, "config after sleep");
		rd(`HBPM_ADR_STATUS);
		chk(d, 32'hc, "flag after sleep");
		@(posedge clk);
		en_oe <= 1'b0;
		repeat (6) @(posedge clk);
		rd(`HBPM_ADR_STATUS);
		chk(d, 32'h8, "released enable");
		// Reset in mid-run
		@(posedge clk);
		en_oe <= 1'b1;
		repeat (6) @(posedge clk);
		wr(`HBPM_ADR_STATUS, 32'h1);
		wr(`HBPM_ADR_ACT, 32'h1);
		wait_out(12'h001, 12'h000);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1 chk({8'h00, hs, ls}, 32'h0, "outputs in reset");
		repeat (6) @(posedge clk);
		rd(`HBPM_ADR_ACT);
		chk(d, 32'h0, "config after reset");
		rd(`HBPM_ADR_STATUS);
		chk(d, 32'hc, "flag after reset");
		report_and_stop;
	end
endmodule
